//--- vdo_regs.svh
`ifndef VDO_REGS_SVH
`define VDO_REGS_SVH

// lane, luma delay setting and pixel counter widths
`define VDO_LANE_W 8
`define VDO_LUMA_DELAY_SETTING_W 3
`define VDO_PIX_W 10

// latency from a word leaving the fifo to the qualified edge that samples it
`define VDO_BASE_LAT 220
// each luma delay step adds one half-rate period so the bus phase is kept
`define VDO_LUMA_DELAY_SETTING_STEP 2

// active pixels per line
`define VDO_PIX_50HZ 10'h300
`define VDO_PIX_60HZ 10'h280

// sync timing, counted in clock cycles after the active line ends
`define VDO_HS_START 8'h10
`define VDO_HS_WIDTH 8'h40
`define VDO_HS_CNT_W 8
// vertical sync length in lines
`define VDO_VS_LINES 4'h6
`define VDO_VS_CNT_W 4

// buffer sizes
`define VDO_FIFO_DEPTH 32
`define VDO_DLY_DEPTH 256

`endif

//--- vdo_pkg.sv
package vdo_pkg;
`include "vdo_regs.svh"

	// one decoded pixel with its framing marks
	typedef struct packed {
		logic line_start;
		logic field_start;
		logic line_ident;
		logic [`VDO_LANE_W-1:0] luma;
		logic [`VDO_LANE_W-1:0] cb;
		logic [`VDO_LANE_W-1:0] cr;
	} vdo_word_t;

	typedef enum logic [0:0] {
		VDO_LN_BLANK = 1'b0,
		VDO_LN_ACTIVE = 1'b1
	} vdo_line_st_t;

endpackage

//--- vdo_fifo.sv
`timescale 1ns/1ps
module vdo_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// fill side
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [WIDTH-1:0] wr_data_i,
	// drain side
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [WIDTH-1:0] rd_data_o
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
			$error("vdo_fifo: depth must be a power of two of at least 2");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} vdo_fifo_state_t;

	vdo_fifo_state_t s_r;
	vdo_fifo_state_t s_nxt;
	logic push;
	logic pop;

	assign wr_ready_o = (s_r.cnt != (AW+1)'(DEPTH));
	assign rd_valid_o = (s_r.cnt != '0);
	assign rd_data_o = s_r.mem[s_r.rp];
	assign push = wr_valid_i & wr_ready_o;
	assign pop = rd_valid_o & rd_ready_i;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = wr_data_i;
			s_nxt.wp = s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + 1'b1;
		end
		case ({push, pop})
			2'b10: s_nxt.cnt = s_r.cnt + 1'b1;
			2'b01: s_nxt.cnt = s_r.cnt - 1'b1;
			default: s_nxt.cnt = s_r.cnt;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

//--- vdo_yuv_out.sv
`timescale 1ns/1ps
module vdo_yuv_out #(
	parameter int FIFO_DEPTH = `VDO_FIFO_DEPTH,
	parameter int DLY_DEPTH = `VDO_DLY_DEPTH,
	parameter int BASE_LAT = `VDO_BASE_LAT
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// decoded sample stream
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic in_line_start_i,
	input wire logic in_field_start_i,
	input wire logic in_line_ident_i,
	input wire logic [`VDO_LANE_W-1:0] in_luma_i,
	input wire logic [`VDO_LANE_W-1:0] in_cb_i,
	input wire logic [`VDO_LANE_W-1:0] in_cr_i,
	// control settings
	input wire logic std_60hz_i,
	input wire logic [`VDO_LUMA_DELAY_SETTING_W-1:0] luma_delay_setting_i,
	input wire logic out_enable_cfg_i,
	input wire logic fast_enable_sel_i,
	input wire logic fast_enable_in_n_i,
	// bus qualifier
	input wire logic clock_qualifier_strobe_i,
	// yuv bus
	output logic [`VDO_LANE_W-1:0] luma_lane_o,
	output logic luma_lane_oe_o,
	output logic [`VDO_LANE_W-1:0] colour_diff_lane_o,
	output logic colour_diff_lane_oe_o,
	output logic output_active_flag_o,
	// line and field timing
	output logic active_line_ref_o,
	output logic horiz_sync_out_o,
	output logic vert_sync_out_o,
	output logic colour_line_ident_o
);
	import vdo_pkg::*;

	localparam int AW = $clog2(DLY_DEPTH);
	localparam int LUMA_DELAY_SETTING_MAX = (1 << `VDO_LUMA_DELAY_SETTING_W) - 1;
	localparam int MAX_OFF = BASE_LAT - 1 + `VDO_LUMA_DELAY_SETTING_STEP * LUMA_DELAY_SETTING_MAX;
	localparam int WORD_W = $bits(vdo_word_t);

	// the delay line needs room for the longest tap and an even base keeps bus phase
	generate
		if ((1 << AW) != DLY_DEPTH || MAX_OFF >= DLY_DEPTH || BASE_LAT < 4
			|| (BASE_LAT % 2) != 0 || FIFO_DEPTH < 2) begin : g_bad_param
			$error("vdo_yuv_out: delay depth or latency out of range");
		end
	endgenerate

	typedef struct packed {
		vdo_word_t [DLY_DEPTH-1:0] mem;
		logic [DLY_DEPTH-1:0] mem_v;
		logic [AW-1:0] wp;
		vdo_line_st_t line_st;
		logic [`VDO_PIX_W-1:0] pix_cnt;
		logic uv_phase;
		logic [`VDO_LANE_W-1:0] luma;
		logic [`VDO_LANE_W-1:0] cdiff;
		logic active_line_ref;
		logic drive_en;
		logic hs_run;
		logic [`VDO_HS_CNT_W-1:0] hs_cnt;
		logic hs;
		logic [`VDO_VS_CNT_W-1:0] vs_cnt;
		logic lid;
	} vdo_state_t;

	vdo_state_t s_r;
	vdo_state_t s_nxt;

	vdo_word_t in_word;
	logic [WORD_W-1:0] fifo_rd_data;
	logic fifo_rd_valid;
	logic fifo_pop;
	vdo_word_t pop_word;
	logic [AW-1:0] tap_off;
	logic [AW-1:0] rd_idx;
	vdo_word_t rd_word;
	logic rd_v;
	logic update_edge;
	logic [`VDO_PIX_W-1:0] line_len;

	assign in_word = '{
		line_start: in_line_start_i,
		field_start: in_field_start_i,
		line_ident: in_line_ident_i,
		luma: in_luma_i,
		cb: in_cb_i,
		cr: in_cr_i
	};

	// input buffer; the fifo only drains on qualified edges, so a fast source stalls
	vdo_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.wr_valid_i(in_valid_i),
		.wr_ready_o(in_ready_o),
		.wr_data_i(in_word),
		.rd_valid_o(fifo_rd_valid),
		.rd_ready_i(clock_qualifier_strobe_i),
		.rd_data_o(fifo_rd_data)
	);

	assign pop_word = vdo_word_t'(fifo_rd_data);
	assign fifo_pop = fifo_rd_valid & clock_qualifier_strobe_i;

	// pop is on a strobe-high edge, so an odd tap lands the update on a strobe-low edge
	// and the partner samples BASE_LAT plus two per step after the pop
	assign tap_off = AW'(BASE_LAT - 1) + AW'({luma_delay_setting_i, 1'b0});
	assign rd_idx = s_r.wp - tap_off;
	assign rd_word = s_r.mem[rd_idx];
	assign rd_v = s_r.mem_v[rd_idx];

	// the bus moves only on edges where the strobe is low, never on the sampling edge
	assign update_edge = ~clock_qualifier_strobe_i;
	assign line_len = std_60hz_i ? `VDO_PIX_60HZ : `VDO_PIX_50HZ;

	always_comb begin
		s_nxt = s_r;

		// delay line written every cycle; empty slots carry a clear valid bit
		s_nxt.mem[s_r.wp] = pop_word;
		s_nxt.mem_v[s_r.wp] = fifo_pop;
		s_nxt.wp = s_r.wp + 1'b1;

		// horizontal sync runs a fixed count after the active line ends
		if (s_r.hs_run) begin
			s_nxt.hs_cnt = s_r.hs_cnt + 1'b1;
			if (s_r.hs_cnt == `VDO_HS_START - 1'b1) begin
				s_nxt.hs = 1'b1;
			end
			if (s_r.hs_cnt == `VDO_HS_START + `VDO_HS_WIDTH - 1'b1) begin
				s_nxt.hs = 1'b0;
				s_nxt.hs_run = 1'b0;
			end
		end

		if (update_edge) begin
			s_nxt.drive_en = fast_enable_sel_i ? ~fast_enable_in_n_i : out_enable_cfg_i;
			s_nxt.active_line_ref = 1'b0;
			if (rd_v) begin
				if (rd_word.line_start) begin
					// new line: blue first, paired with the first luma sample
					s_nxt.line_st = VDO_LN_ACTIVE;
					s_nxt.pix_cnt = `VDO_PIX_W'(1);
					s_nxt.luma = rd_word.luma;
					s_nxt.cdiff = rd_word.cb;
					s_nxt.uv_phase = 1'b1;
					s_nxt.active_line_ref = 1'b1;
					s_nxt.lid = rd_word.line_ident;
					if (rd_word.field_start) begin
						s_nxt.vs_cnt = `VDO_VS_LINES;
					end
				end else if (s_r.line_st == VDO_LN_ACTIVE) begin
					// pixels counted only inside the active line
					s_nxt.pix_cnt = s_r.pix_cnt + 1'b1;
					s_nxt.luma = rd_word.luma;
					s_nxt.cdiff = s_r.uv_phase ? rd_word.cr : rd_word.cb;
					s_nxt.uv_phase = ~s_r.uv_phase;
					s_nxt.active_line_ref = 1'b1;
				end
				if ((rd_word.line_start || s_r.line_st == VDO_LN_ACTIVE)
					&& s_nxt.pix_cnt == line_len) begin
					// line full: close it and time the syncs from here
					s_nxt.line_st = VDO_LN_BLANK;
					s_nxt.uv_phase = 1'b0;
					s_nxt.hs_run = 1'b1;
					s_nxt.hs_cnt = '0;
					s_nxt.hs = 1'b0;
					if (s_nxt.vs_cnt != '0) begin
						s_nxt.vs_cnt = s_nxt.vs_cnt - 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign luma_lane_o = s_r.luma;
	assign colour_diff_lane_o = s_r.cdiff;
	assign luma_lane_oe_o = s_r.drive_en;
	assign colour_diff_lane_oe_o = s_r.drive_en;
	assign output_active_flag_o = s_r.drive_en;
	assign active_line_ref_o = s_r.active_line_ref;
	assign horiz_sync_out_o = s_r.hs;
	assign vert_sync_out_o = (s_r.vs_cnt != '0);
	assign colour_line_ident_o = s_r.lid;
endmodule

//--- vdo_yuv_out_asserts.sv
`timescale 1ns/1ps
`include "vdo_regs.svh"
module vdo_yuv_out_asserts (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// controls
	input wire logic clock_qualifier_strobe_i,
	input wire logic out_enable_cfg_i,
	input wire logic fast_enable_sel_i,
	input wire logic fast_enable_in_n_i,
	// bus
	input wire logic [`VDO_LANE_W-1:0] luma_lane_o,
	input wire logic [`VDO_LANE_W-1:0] colour_diff_lane_o,
	input wire logic luma_lane_oe_o,
	input wire logic colour_diff_lane_oe_o,
	input wire logic output_active_flag_o,
	input wire logic active_line_ref_o,
	input wire logic horiz_sync_out_o
);
	wire logic en_w = fast_enable_sel_i ? ~fast_enable_in_n_i : out_enable_cfg_i;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_hs_run;
		horiz_sync_out_o [*8];
	endsequence
	property p_flag; output_active_flag_o == luma_lane_oe_o; endproperty
	a_flag: assert property (p_flag) else $error("flag");
	property p_oe_pair; colour_diff_lane_oe_o == luma_lane_oe_o; endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("oe pair");
	property p_oe_src; !clock_qualifier_strobe_i |=> luma_lane_oe_o == $past(en_w); endproperty
	a_oe_src: assert property (p_oe_src) else $error("oe source");
	property p_y_hold; clock_qualifier_strobe_i |=> $stable(luma_lane_o); endproperty
	a_y_hold: assert property (p_y_hold) else $error("luma hold");
	property p_c_hold; clock_qualifier_strobe_i |=> $stable(colour_diff_lane_o); endproperty
	a_c_hold: assert property (p_c_hold) else $error("colour hold");
	property p_ref_hold; clock_qualifier_strobe_i |=> $stable(active_line_ref_o); endproperty
	a_ref_hold: assert property (p_ref_hold) else $error("active_line_ref hold");
	property p_hs_len; $rose(horiz_sync_out_o) |-> s_hs_run; endproperty
	a_hs_len: assert property (p_hs_len) else $error("hsync width");
	property p_hs_gap; $rose(horiz_sync_out_o) |-> !active_line_ref_o; endproperty
	a_hs_gap: assert property (p_hs_gap) else $error("hsync in line");
endmodule
bind vdo_yuv_out vdo_yuv_out_asserts u_chk (.*);

//--- vdo_sink.sv
`timescale 1ns/1ps
`include "vdo_regs.svh"
module vdo_sink (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// bus in
	input wire logic active_line_ref_i,
	input wire logic oe_i,
	input wire logic [`VDO_LANE_W-1:0] luma_i,
	input wire logic [`VDO_LANE_W-1:0] cdiff_i,
	// strobe out and captured words
	output logic strobe_o,
	output logic got_o,
	output logic [`VDO_LANE_W-1:0] luma_o,
	output logic [`VDO_LANE_W-1:0] cdiff_o
);
	// alternating strobe keeps every party in phase
	always @(negedge ref_clk_i or posedge rst_i) strobe_o <= rst_i ? 1'b0 : ~strobe_o;
	always @(posedge ref_clk_i) begin
		got_o <= !rst_i && strobe_o && active_line_ref_i && oe_i;
		luma_o <= luma_i;
		cdiff_o <= cdiff_i;
	end
endmodule

//--- video_decoder_yuv_output_port_bench.sv
`timescale 1ns/1ps
`define CHK(n,e,g) begin total_checks++; if ((g)!==(e)) begin err_total++; \
	$display("FAIL %s exp %h got %h", n, e, g); end end
module video_decoder_yuv_output_port_bench;
	import vdo_pkg::*;
	logic ref_clk_i = 0, rst_i = 1, in_valid_i = 0, ls = 0, fs = 0, id = 0, std = 0;
	logic cfg = 0, fsel = 0, fen_n = 1, strobe, got, rdy, loe, coe, flag, active_line_ref, hs, vs, ident;
	logic [`VDO_LUMA_DELAY_SETTING_W-1:0] luma_delay_setting = 0;
	logic [`VDO_LANE_W-1:0] y = 0, b = 0, r = 0, gy, gc, ly, lc;
	logic [2*`VDO_LANE_W-1:0] ew, expq[$];
	int err_total = 0, total_checks = 0, cyc = 0;
	always #25 ref_clk_i = ~ref_clk_i;
	vdo_yuv_out u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .in_valid_i(in_valid_i),
		.in_ready_o(rdy), .in_line_start_i(ls), .in_field_start_i(fs), .in_line_ident_i(id),
		.in_luma_i(y), .in_cb_i(b), .in_cr_i(r), .std_60hz_i(std), .luma_delay_setting_i(luma_delay_setting),
		.out_enable_cfg_i(cfg), .fast_enable_sel_i(fsel), .fast_enable_in_n_i(fen_n),
		.clock_qualifier_strobe_i(strobe), .luma_lane_o(ly), .luma_lane_oe_o(loe),
		.colour_diff_lane_o(lc), .colour_diff_lane_oe_o(coe), .output_active_flag_o(flag),
		.active_line_ref_o(active_line_ref), .horiz_sync_out_o(hs), .vert_sync_out_o(vs),
		.colour_line_ident_o(ident));
	vdo_sink u_sink (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .active_line_ref_i(active_line_ref), .oe_i(loe),
		.luma_i(ly), .cdiff_i(lc), .strobe_o(strobe), .got_o(got), .luma_o(gy), .cdiff_o(gc));
	function automatic logic [`VDO_LANE_W-1:0] exp_c(int i, logic [`VDO_LANE_W-1:0] cb, cr);
		return i[0] ? cr : cb;
	endfunction
	task automatic results;
		if (err_total == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// two words past the line length must be dropped
	task automatic line(input int n, input logic f);
		for (int i = 0; i < n + 2; i++) begin
			@(negedge ref_clk_i);
			in_valid_i = 1;
			ls = (i == 0);
			fs = f && (i == 0);
			y = (i == n - 1) ? 8'hff : 8'($urandom);
			b = 8'($urandom);
			r = 8'($urandom);
			if (i < n) expq.push_back({y, exp_c(i, b, r)});
			while (rdy !== 1'b1) @(negedge ref_clk_i);
		end
		@(negedge ref_clk_i);
		in_valid_i = 0;
		for (int k = 0; k < 3000 && expq.size() > 0; k++) @(negedge ref_clk_i);
	endtask
	always @(negedge ref_clk_i) begin
		if (got === 1'b1) begin
			ew = expq.size() > 0 ? expq.pop_front() : 'x;
			`CHK("bus word", ew, {gy, gc})
		end
	end
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			results;
		end
	end
	initial begin
		void'($urandom(32'hfa50));
		for (int t = 0; t < 2; t++) begin
			rst_i = 1;
			std = t[0];
			cfg = !t[0];
			fsel = t[0];
			fen_n = !t[0];
			luma_delay_setting = 3'($urandom);
			repeat (6) @(negedge ref_clk_i);
			rst_i = 0;
			for (int l = 0; l < 2; l++) begin
				id = 1'($urandom);
				line(t ? `VDO_PIX_60HZ : `VDO_PIX_50HZ, l == 0);
				`CHK("words left", 0, expq.size())
				`CHK("ident", id, ident)
				`CHK("vsync", 1'b1, vs)
				`CHK("flag on", 1'b1, flag)
			end
			cfg = 0;
			fen_n = 1;
			repeat (4) @(negedge ref_clk_i);
			`CHK("flag off", 1'b0, flag)
		end
		results;
	end
endmodule
